// ===== bench/rtdc_checker_asserts.sv
// Port checker for the direction control block.
// Assumes bound to rtdc_top, one clock domain.
`timescale 1ns/100ps
module rtdc_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [rtdc_pkg::ADDR_W-1:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatI,
    input wire logic wbAck,
    // Port side
    input wire rtdc_pkg::rtdc_uart_t [rtdc_pkg::NUM_PORTS-1:0] uart,
    input wire rtdc_pkg::rtdc_xcvr_t [rtdc_pkg::NUM_PORTS-1:0] xcvr
);
    import rtdc_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic [7:0] modeSeen [NUM_PORTS];
    wire wrHit = wbCyc && wbStb && wbAck && wbWe && wbSel[0];
    ////////////////////////////////////////////////////////////
    // Mode as written by the host
    always_ff @(posedge clk) begin
        if (rst) begin
            modeSeen <= '{default: MODE_RESET};
        end else if (wrHit && wbAdr == MODE_ADDR0) begin
            modeSeen[0] <= wbDatI[7:0];
        end else if (wrHit && wbAdr == MODE_ADDR1) begin
            modeSeen[1] <= wbDatI[7:0];
        end
    end
    ////////////////////////////////////////////////////////////
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        a_four_wire: assert property ((modeSeen[p] == 0 || modeSeen[p] > 3) |-> xcvr[p] == 2'b11)
            else $error("four-wire enables");
        a_echo_drv: assert property (modeSeen[p] == 1 |-> xcvr[p].drvEn == $past(uart[p].dtrN))
            else $error("echo driver");
        a_echo_rcv: assert property (modeSeen[p] == 1 |-> xcvr[p].rcvEn)
            else $error("echo receiver");
        a_quiet_pair: assert property (modeSeen[p] == 2 |-> xcvr[p] == {$past(uart[p].dtrN), !$past(uart[p].dtrN)})
            else $error("quiet enables");
        a_auto_drv: assert property (modeSeen[p] == 3 |-> xcvr[p].drvEn != $past(uart[p].transmit_holding_ready_n))
            else $error("auto driver");
        a_auto_rcv: assert property (modeSeen[p] == 3 |-> xcvr[p].rcvEn != xcvr[p].drvEn)
            else $error("auto receiver");
        cover property (modeSeen[p] == 3 && xcvr[p].drvEn);
    end
    a_reset_mode: assert property (disable iff (1'b0) rst |=> xcvr == '1)
        else $error("reset enables");
    a_ack_delay: assert property ($rose(wbCyc && wbStb) |-> !wbAck ##2 wbAck)
        else $error("ack timing");
    a_ack_pulse: assert property (wbAck |=> !wbAck)
        else $error("ack width");
    cover property (wrHit && wbAdr == MODE_ADDR1);
    cover property (modeSeen[0] == 2 && !xcvr[0].drvEn);
endmodule
bind rtdc_top rtdc_checker i_rtdc_checker (.clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbAck(wbAck), .uart(uart), .xcvr(xcvr));

// ===== bench/rtdc_line_model.sv
// One RS-485 transceiver on a biased pair.
// Assumes enables from the block, data bit from the bench.
`timescale 1ns/100ps
module rtdc_line_model (
    // Enables
    input wire rtdc_pkg::rtdc_xcvr_t xcvr,
    // Data
    input wire logic txBit,
    output logic busLine,
    output logic rxOut
);
    import rtdc_pkg::*;
    // Released pair idles high through bias resistors
    assign busLine = xcvr.drvEn ? txBit : 1'b1;
    // Disabled receiver output floats to its pull-up
    assign rxOut = xcvr.rcvEn ? busLine : 1'b1;
endmodule

// ===== bench/tb.sv
// Testbench for the direction control block.
// Assumes design, checker and line model compiled first.
`timescale 1ns/100ps
module tb;
    import rtdc_pkg::*;
    logic clk, rst, wbCyc, wbStb, wbWe, wbAck, irq, txBit, randOn;
    logic [ADDR_W-1:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatI, wbDatO, rd;
    logic [NUM_PORTS-1:0] rxPush, rxPop, txPush, txPop, rxOut;
    rtdc_uart_t [NUM_PORTS-1:0] uart, uPrev, uNext;
    rtdc_xcvr_t [NUM_PORTS-1:0] xcvr;
    logic [1:0] e;
    int mode [NUM_PORTS];
    int num_errors, n_tests, cycles;
    logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hA5};
    rtdc_top i_rtdc_top (.clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .uart(uart),
        .rxCharPush(rxPush), .rxCharPop(rxPop), .txCharPush(txPush), .txCharPop(txPop),
        .xcvr(xcvr), .irq(irq));
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_line
        rtdc_line_model i_rtdc_line_model (.xcvr(xcvr[p]), .txBit(txBit), .busLine(), .rxOut(rxOut[p]));
    end
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wb(input logic we, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk);
        {wbCyc, wbStb, wbWe, wbAdr, wbDatI, wbSel} <= {2'b11, we, a, d, s};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        check(wbAck, 1'b1);
        rd = wbDatO;
        {wbCyc, wbStb} <= 2'b00;
    endtask
    function automatic logic [1:0] exp_x(input int m, input rtdc_uart_t u);
        case (m)
            1: return {u.dtrN, 1'b1};
            2: return {u.dtrN, ~u.dtrN};
            3: return {~u.transmit_holding_ready_n, u.transmit_holding_ready_n};
            default: return 2'b11;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////
    // Random line stimulus and timeout
    always @(posedge clk) begin
        uPrev = uart;
        if (randOn) begin
            uNext = 4'($urandom);
            uart <= uNext;
            // Host sends only while both DTR lines are deasserted
            txBit <= 1'($urandom) | ~(uNext[0].dtrN & uNext[1].dtrN);
        end
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    // Model compare every cycle out of reset
    always @(negedge clk) begin
        if (!rst) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                e = exp_x(mode[p], uPrev[p]);
                check(xcvr[p], e);
                check(rxOut[p], e[0] ? (e[1] ? txBit : 1'b1) : 1'b1);
            end
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        {wbCyc, wbStb, wbWe, randOn, txBit, wbAdr, wbSel, wbDatI, uart} = '0;
        {rxPush, rxPop, txPush, txPop} = '0;
        mode = '{default: 0};
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        void'($urandom(32'h1c2c));
        randOn <= 1'b1;
        for (int p = 0; p < NUM_PORTS; p++) begin
            wb(0, p ? MODE_ADDR1 : MODE_ADDR0, 0, 4'hF);
            check(rd, MODE_RESET);
        end
        wb(0, FIFO_ADDR0, 0, 4'hF);
        check(rd, FIFO_CFG_RESET);
        wb(1, 8'h60, 32'hFF, 4'hF);
        wb(0, 8'h60, 0, 4'hF);
        check(rd, 0);
        foreach (codes[i]) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                wb(1, p ? MODE_ADDR1 : MODE_ADDR0, {24'h0, codes[i]}, 4'hF);
                mode[p] = codes[i];
                wb(1, p ? MODE_ADDR1 : MODE_ADDR0, 32'h3, 4'hE);
                repeat ($urandom_range(12, 4)) @(posedge clk);
                for (int q = 0; q < NUM_PORTS; q++) begin
                    wb(0, q ? MODE_ADDR1 : MODE_ADDR0, 0, 4'hF);
                    check(rd, mode[q]);
                end
            end
        end
        wb(0, LINE_ADDR, 0, 4'hF);
        check(rd, 32'hF);
        wb(1, MASK_ADDR, 32'h1, 4'hF);
        wb(0, MASK_ADDR, 0, 4'hF);
        check(rd, 32'h1);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            rxPush <= 2'b01;
            @(posedge clk);
            {rxPush, rxPop} <= 4'b0001;
            @(posedge clk);
            rxPop <= 2'b00;
            wb(0, STAT_ADDR, 0, 4'hF);
            check(rd[0], 1'b1);
            check(irq, k == 0);
            wb(1, STAT_ADDR, 32'h1, 4'hF);
            wb(0, STAT_ADDR, 0, 4'hF);
            check({rd[0], irq}, 2'b00);
            wb(1, MASK_ADDR, 32'h0, 4'hF);
        end
        // Tx FIFO drains to empty: space event
        wb(1, STAT_ADDR, 32'hF, 4'hF);
        @(posedge clk);
        txPush <= 2'b01;
        @(posedge clk);
        {txPush, txPop} <= 4'b0001;
        @(posedge clk);
        txPop <= 2'b00;
        wb(0, STAT_ADDR, 0, 4'hF);
        check(rd[1], 1'b1);
        wrap_up();
    end
endmodule

// ===== src/rtdc_mode_regs.sv
// Per-port mode and FIFO configuration store.
// Assumes writes are qualified by the bus slave; read data registered.
`timescale 1ns/100ps
module rtdc_mode_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Write side
    input wire logic wrMode,
    input wire logic wrFifo,
    input wire logic [0:0] wrPort,
    input wire logic [7:0] wrData,
    // Read side
    input wire logic [0:0] rdPort,
    input wire logic rdFifo,
    output logic [7:0] rdData,
    // Live values
    output logic [rtdc_pkg::NUM_PORTS*8-1:0] modeAll,
    output logic [rtdc_pkg::NUM_PORTS*8-1:0] fifoAll
);
    import rtdc_pkg::*;

    logic [7:0] modeMem [NUM_PORTS];
    logic [7:0] fifoMem [NUM_PORTS];

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            always_ff @(posedge clk) begin
                if (rst) begin
                    modeMem[p] <= MODE_RESET; // R12
                end else if (wrMode && wrPort == 1'(p)) begin
                    modeMem[p] <= wrData; // R9
                end
            end
            always_ff @(posedge clk) begin
                if (rst) begin
                    fifoMem[p] <= FIFO_CFG_RESET;
                end else if (wrFifo && wrPort == 1'(p)) begin
                    fifoMem[p] <= wrData;
                end
            end
            assign modeAll[p*8 +: 8] = modeMem[p];
            assign fifoAll[p*8 +: 8] = fifoMem[p];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            rdData <= 8'h00;
        end else begin
            rdData <= rdFifo ? fifoMem[rdPort] : modeMem[rdPort];
        end
    end
endmodule

// ===== src/rtdc_pkg.sv
// Package for the transceiver direction control block.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package rtdc_pkg;
    localparam int NUM_PORTS = 2;
    localparam int ADDR_W = 8;
    // Register byte addresses; offset 7 is a register index, byte address = 4 * index
    localparam logic [ADDR_W-1:0] MODE_IDX = 8'h07;
    localparam logic [ADDR_W-1:0] PORT_STRIDE = 8'h08;
    localparam logic [ADDR_W-1:0] MODE_ADDR0 = 8'h1C;
    localparam logic [ADDR_W-1:0] MODE_ADDR1 = 8'h3C;
    localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h40;
    localparam logic [ADDR_W-1:0] MASK_ADDR = 8'h44;
    localparam logic [ADDR_W-1:0] FIFO_ADDR0 = 8'h48;
    localparam logic [ADDR_W-1:0] FIFO_ADDR1 = 8'h4C;
    localparam logic [ADDR_W-1:0] LINE_ADDR = 8'h50;
    // Reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] FIFO_CFG_RESET = 8'h81;
    // Mode codes
    localparam logic [7:0] MODE_FOUR_WIRE = 8'h00;
    localparam logic [7:0] MODE_DTR_ECHO = 8'h01;
    localparam logic [7:0] MODE_DTR_QUIET = 8'h02;
    localparam logic [7:0] MODE_AUTO = 8'h03;
    // FIFO config field positions: rx threshold [3:0], tx block size [7:4]
    localparam int RX_THR_LSB = 0;
    localparam int TX_BLK_LSB = 4;
    localparam int FIFO_CNT_W = 5;
    // Status bits per port: bit 2p rx threshold reached, bit 2p+1 tx space available
    localparam int STAT_W = 2 * NUM_PORTS;

    typedef struct packed {
        logic dtrN;
        logic transmit_holding_ready_n;
    } rtdc_uart_t;

    typedef struct packed {
        logic drvEn;
        logic rcvEn;
    } rtdc_xcvr_t;
endpackage

// ===== src/rtdc_top.sv
// RS-485 transceiver direction control for two UART ports.
// Assumes UART status inputs are synchronous to clk; Wishbone classic slave.
//
// What this block does
// R1: Four-wire mode keeps driver and receiver enabled always; it is the default.
// R2: Echo two-wire mode: driver off while DTR asserted, on while deasserted.
// R3: Echo two-wire mode keeps the receiver always enabled.
// R4: Quiet two-wire mode: driver from DTR, receiver on only while DTR asserted.
// R5: Host clears DTR before sending and sets it after the last bit leaves.
// R6: Auto two-wire mode drives the driver enable from transmit ready.
// R7: Auto two-wire mode: receiver off whenever the driver is on.
// R8: Mode byte 0 four-wire, 1 echo, 2 quiet, 3 auto.
// R9: Mode byte lives in a per-port eight-bit register at index 7.
// R10: A newly written mode reaches the transceiver enables one clock edge after it is stored.
// R11: Separate rx/tx FIFO counts; interrupt at rx threshold, tx requests in blocks.
// R12: Reset sets every port's mode to four-wire.
`timescale 1ns/100ps
module rtdc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [rtdc_pkg::ADDR_W-1:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatI,
    output logic [31:0] wbDatO,
    output logic wbAck,
    // UART side per port
    input wire rtdc_pkg::rtdc_uart_t [rtdc_pkg::NUM_PORTS-1:0] uart,
    input wire logic [rtdc_pkg::NUM_PORTS-1:0] rxCharPush,
    input wire logic [rtdc_pkg::NUM_PORTS-1:0] rxCharPop,
    input wire logic [rtdc_pkg::NUM_PORTS-1:0] txCharPush,
    input wire logic [rtdc_pkg::NUM_PORTS-1:0] txCharPop,
    // Transceiver enables per port
    output rtdc_pkg::rtdc_xcvr_t [rtdc_pkg::NUM_PORTS-1:0] xcvr,
    // Interrupt
    output logic irq
);
    import rtdc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic req;
    logic hitMode;
    logic hitFifo;
    logic [0:0] selPort;
    logic wrEn;
    logic [7:0] regRdData;
    logic [NUM_PORTS*8-1:0] modeAll;
    logic [NUM_PORTS*8-1:0] fifoAll;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] mask;
    logic [STAT_W-1:0] events;
    logic ackPend;
    logic fromRegs;
    logic [31:0] directData;
    logic [31:0] next_datO;

    assign req = wbCyc && wbStb && !wbAck;
    assign hitMode = (wbAdr == MODE_ADDR0) || (wbAdr == MODE_ADDR1);
    assign hitFifo = (wbAdr == FIFO_ADDR0) || (wbAdr == FIFO_ADDR1);
    assign selPort = (wbAdr == MODE_ADDR1 || wbAdr == FIFO_ADDR1) ? 1'b1 : 1'b0;
    assign wrEn = req && ackPend && wbWe && wbSel[0];

    rtdc_mode_regs u_regs (
        .clk(clk),
        .rst(rst),
        .wrMode(wrEn && hitMode), // R9
        .wrFifo(wrEn && hitFifo),
        .wrPort(selPort),
        .wrData(wbDatI[7:0]),
        .rdPort(selPort),
        .rdFifo(hitFifo),
        .rdData(regRdData),
        .modeAll(modeAll),
        .fifoAll(fifoAll)
    );

    ////////////////////////////////////////////////////////////////////////
    // Two-cycle answer: wait state lets the store register its read data
    always_ff @(posedge clk) begin
        if (rst) begin
            ackPend <= 1'b0;
        end else begin
            ackPend <= req && !ackPend;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wbAck <= 1'b0;
        end else begin
            wbAck <= req && ackPend;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fromRegs <= 1'b0;
            directData <= 32'h0000_0000;
        end else if (req && !ackPend) begin
            fromRegs <= hitMode || hitFifo;
            case (wbAdr)
                STAT_ADDR: directData <= {{(32-STAT_W){1'b0}}, status};
                MASK_ADDR: directData <= {{(32-STAT_W){1'b0}}, mask};
                LINE_ADDR: directData <= {{(32-2*NUM_PORTS){1'b0}}, xcvr};
                default: directData <= 32'h0000_0000;
            endcase
        end
    end

    assign next_datO = fromRegs ? {24'h00_0000, regRdData} : directData;

    // Read data launched with ack, straight from a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            wbDatO <= 32'h0000_0000;
        end else if (req && ackPend) begin
            wbDatO <= next_datO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transceiver enables, decoded combinationally from live mode, registered once
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_xcvr
            logic [7:0] mode;
            logic dtrAsserted;
            logic txActive;
            rtdc_xcvr_t next_xcvr;
            assign mode = modeAll[p*8 +: 8];
            assign dtrAsserted = !uart[p].dtrN;
            assign txActive = !uart[p].transmit_holding_ready_n;

            always_comb begin
                next_xcvr.drvEn = 1'b1; // R1
                next_xcvr.rcvEn = 1'b1; // R1
                case (mode) // R8
                    MODE_DTR_ECHO: begin
                        next_xcvr.drvEn = !dtrAsserted; // R2
                        next_xcvr.rcvEn = 1'b1; // R3
                    end
                    MODE_DTR_QUIET: begin
                        next_xcvr.drvEn = !dtrAsserted; // R4
                        next_xcvr.rcvEn = dtrAsserted; // R4
                    end
                    MODE_AUTO: begin
                        next_xcvr.drvEn = txActive; // R6
                        next_xcvr.rcvEn = !txActive; // R7
                    end
                    default: begin
                        next_xcvr.drvEn = 1'b1;
                        next_xcvr.rcvEn = 1'b1;
                    end
                endcase
            end

            // Mode write becomes visible one edge after it is stored
            always_ff @(posedge clk) begin
                if (rst) begin
                    xcvr[p] <= 2'b11; // R12
                end else begin
                    xcvr[p] <= next_xcvr; // R10
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // FIFO fill tracking and threshold events
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_fifo
            logic [FIFO_CNT_W-1:0] rxCount;
            logic [FIFO_CNT_W-1:0] txCount;
            logic [FIFO_CNT_W-1:0] rxThr;
            logic [FIFO_CNT_W-1:0] txBlk;
            logic rxAbove;
            logic rxAboveQ;
            logic txRoom;
            logic txRoomQ;
            assign rxThr = {1'b0, fifoAll[p*8 + RX_THR_LSB +: 4]};
            assign txBlk = {1'b0, fifoAll[p*8 + TX_BLK_LSB +: 4]};

            always_ff @(posedge clk) begin
                if (rst) begin
                    rxCount <= '0;
                end else if (rxCharPush[p] && !rxCharPop[p]) begin
                    rxCount <= rxCount + 5'd1;
                end else if (rxCharPop[p] && !rxCharPush[p] && rxCount != '0) begin
                    rxCount <= rxCount - 5'd1;
                end
            end

            always_ff @(posedge clk) begin
                if (rst) begin
                    txCount <= '0;
                end else if (txCharPush[p] && !txCharPop[p]) begin
                    txCount <= txCount + 5'd1;
                end else if (txCharPop[p] && !txCharPush[p] && txCount != '0) begin
                    txCount <= txCount - 5'd1;
                end
            end

            assign rxAbove = (rxCount >= rxThr) && (rxThr != '0); // R11
            assign txRoom = (txCount == '0) && (txBlk != '0); // R11

            always_ff @(posedge clk) begin
                if (rst) begin
                    rxAboveQ <= 1'b0;
                    txRoomQ <= 1'b0;
                end else begin
                    rxAboveQ <= rxAbove;
                    txRoomQ <= txRoom;
                end
            end

            assign events[2*p] = rxAbove && !rxAboveQ; // R11
            assign events[2*p+1] = txRoom && !txRoomQ; // R11
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, mask and output
    always_ff @(posedge clk) begin
        if (rst) begin
            status <= '0;
        end else if (wrEn && wbAdr == STAT_ADDR) begin
            status <= (status & ~wbDatI[STAT_W-1:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mask <= '0;
        end else if (wrEn && wbAdr == MASK_ADDR) begin
            mask <= wbDatI[STAT_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end
endmodule
